// *** rtl/adc_ctrl.sv ***
// Serial port and conversion sequencer of the integrating converter
// Contract
// - Serial traffic is accepted only while chip select is low.
// - A rising chip select edge moves the input shift register into the command register.
// - A falling chip select edge loads the output shift register from the result FIFO, or with zero when the FIFO is empty.
// - Serial data out is released whenever chip select is high.
// - Input bits are sampled on rising serial clock, top bit first.
// - Output bits change on falling serial clock, top bit first.
// - Four user outputs follow values written over the serial port.
// - End of conversion goes high when a conversion completes.
// - Each conversion integrates for a fixed count before deintegration.
// - Deintegration counts oscillator clocks until the zero crossing; the count is the result.
// - Line mode picks 655 clocks for 50 Hz and 545 clocks for 60 Hz.
module adc_ctrl #(
  parameter int CNT_MAX = 32'h000F_FFFF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial port pins
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Oscillator and analog front end
  input wire logic oscillator_in_i,
  input wire logic zero_cross_i,
  output logic integrate_o,
  output logic deintegrate_o,
  // Status and user pins
  output logic eoc_o,
  output logic [3:0] user_outputs_o,
  output logic mode_50hz_o
);
  import adc_ctrl_pkg::*;

  typedef enum {S_IDLE, S_INT, S_DEINT} seq_t;

  // Three-stage input synchronisers
  logic [2:0] cs_s, sclk_s, din_s, osc_s, zc_s;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cs_s <= 3'h7;
      sclk_s <= 3'h0;
      din_s <= 3'h0;
      osc_s <= 3'h0;
      zc_s <= 3'h0;
    end else begin
      cs_s <= {cs_s[1:0], cs_b_i};
      sclk_s <= {sclk_s[1:0], sclk_i};
      din_s <= {din_s[1:0], din_i};
      osc_s <= {osc_s[1:0], oscillator_in_i};
      zc_s <= {zc_s[1:0], zero_cross_i};
    end
  end

  logic cs_q, sclk_q, osc_q;
  logic next_cs_q, next_sclk_q, next_osc_q;
  logic cs_rise, cs_fall, sclk_rise, sclk_fall, osc_tick, zc_now;
  always_comb begin
    next_cs_q = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_q;
    next_sclk_q = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
    next_osc_q = (osc_s[1] == osc_s[2]) ? osc_s[2] : osc_q;
    cs_rise = next_cs_q && !cs_q;
    cs_fall = !next_cs_q && cs_q;
    sclk_rise = next_sclk_q && !sclk_q && !cs_q;
    sclk_fall = !next_sclk_q && sclk_q && !cs_q;
    osc_tick = next_osc_q && !osc_q;
    zc_now = zc_s[1] && zc_s[2];
  end

  // Serial port state
  logic [BYTE_W-1:0] in_sr, next_in_sr, out_sr, next_out_sr, cmd, next_cmd;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [3:0] user, next_user;
  logic mode50, next_mode50, start_req, next_start_req;
  logic dout, next_dout, oe, next_oe;
  logic fifo_pop, fifo_valid;
  logic [BYTE_W-1:0] fifo_data;

  always_comb begin
    next_in_sr = in_sr;
    next_out_sr = out_sr;
    next_bit_cnt = bit_cnt;
    next_cmd = cmd;
    next_user = user;
    next_mode50 = mode50;
    next_start_req = 1'b0;
    next_dout = dout;
    fifo_pop = 1'b0;
    next_oe = !next_cs_q;
    if (sclk_rise) begin
      next_in_sr = {in_sr[BYTE_W-2:0], din_s[2]};
    end
    if (sclk_fall) begin
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_out_sr = fifo_valid ? fifo_data : out_sr;
        fifo_pop = fifo_valid;
      end else begin
        next_out_sr = {out_sr[BYTE_W-2:0], 1'b0};
      end
      next_dout = next_out_sr[BYTE_W-1];
    end
    if (cs_fall) begin
      next_out_sr = fifo_valid ? fifo_data : 8'h00;
      fifo_pop = fifo_valid;
      next_dout = next_out_sr[BYTE_W-1];
      next_bit_cnt = 3'h0;
    end
    if (cs_rise) begin
      next_cmd = in_sr;
      next_mode50 = in_sr[CMD_MODE_BIT];
      next_start_req = in_sr[CMD_START_BIT];
      if (in_sr[CMD_USER_BIT]) begin
        next_user = in_sr[CMD_USER_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      osc_q <= 1'b0;
      in_sr <= CMD_RST;
      out_sr <= CMD_RST;
      cmd <= CMD_RST;
      bit_cnt <= 3'h0;
      user <= USER_OUT_RST;
      mode50 <= 1'b0;
      start_req <= 1'b0;
      dout <= 1'b0;
      oe <= 1'b0;
    end else begin
      cs_q <= next_cs_q;
      sclk_q <= next_sclk_q;
      osc_q <= next_osc_q;
      in_sr <= next_in_sr;
      out_sr <= next_out_sr;
      cmd <= next_cmd;
      bit_cnt <= next_bit_cnt;
      user <= next_user;
      mode50 <= next_mode50;
      start_req <= next_start_req;
      dout <= next_dout;
      oe <= next_oe;
    end
  end

  // Conversion sequencer
  seq_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, int_len;
  logic eoc, next_eoc, push, integ_q, deint_q;
  logic [RESULT_W-1:0] result, next_result;
  logic [1:0] push_idx, next_push_idx;
  logic fifo_ready;
  logic [BYTE_W-1:0] push_byte;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_eoc = eoc;
    next_result = result;
    next_push_idx = push_idx;
    int_len = mode50 ? INT_CLKS_50HZ : INT_CLKS_60HZ;
    push = (push_idx != 2'h0) && fifo_ready;
    push_byte = (push_idx == 2'h3) ? {4'h0, result[19:16]} :
      (push_idx == 2'h2) ? result[15:8] : result[7:0];
    if (push) begin
      next_push_idx = push_idx - 2'h1;
    end
    case (state)
      S_IDLE: begin
        if (start_req) begin
          next_eoc = 1'b0;
          next_cnt = '0;
          next_state = S_INT;
        end
      end
      S_INT: begin
        if (osc_tick) begin
          next_cnt = cnt + 20'h0_0001;
          if (next_cnt == int_len) begin
            next_cnt = '0;
            next_state = S_DEINT;
          end
        end
      end
      S_DEINT: begin
        if (zc_now || cnt == CNT_MAX[CNT_W-1:0]) begin
          next_result = cnt;
          next_eoc = 1'b1;
          next_push_idx = 2'(RESULT_BYTES);
          next_state = S_IDLE;
        end else if (osc_tick) begin
          next_cnt = cnt + 20'h0_0001;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      cnt <= '0;
      eoc <= 1'b0;
      result <= '0;
      push_idx <= 2'h0;
      integ_q <= 1'b0;
      deint_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      eoc <= next_eoc;
      result <= next_result;
      push_idx <= next_push_idx;
      integ_q <= (next_state == S_INT);
      deint_q <= (next_state == S_DEINT);
    end
  end

  byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_byte),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  assign dout_o = dout;
  assign dout_oe_o = oe;
  assign eoc_o = eoc;
  assign user_outputs_o = user;
  assign mode_50hz_o = mode50;
  assign integrate_o = integ_q;
  assign deintegrate_o = deint_q;

  property p_oe_off;
    @(posedge clk_i) disable iff (!rst_b_i) (cs_s[2] && cs_s[1]) |=> !oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("dout driven while deselected");
  property p_cmd_load;
    @(posedge clk_i) disable iff (!rst_b_i) cs_rise |=> cmd == $past(in_sr);
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command not loaded");
  sequence s_conv_start;
    state == S_IDLE && start_req;
  endsequence
  property p_eoc_clear;
    @(posedge clk_i) disable iff (!rst_b_i) s_conv_start |=> !eoc;
  endproperty
  a_eoc_clear: assert property (p_eoc_clear) else $error("eoc not cleared");
  property p_eoc_set;
    @(posedge clk_i) disable iff (!rst_b_i) $rose(eoc) |-> $past(state) == S_DEINT;
  endproperty
  a_eoc_set: assert property (p_eoc_set) else $error("eoc rose outside completion");
  property p_user_hold;
    @(posedge clk_i) disable iff (!rst_b_i) !cs_rise |=> $stable(user);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user outputs moved");
  property p_int_len;
    @(posedge clk_i) disable iff (!rst_b_i) (state == S_INT && next_state == S_DEINT) |->
      cnt == (mode50 ? INT_CLKS_50HZ : INT_CLKS_60HZ) - 20'h0_0001;
  endproperty
  a_int_len: assert property (p_int_len) else $error("wrong integration length");
  property p_int_first;
    @(posedge clk_i) disable iff (!rst_b_i) (state == S_DEINT) |-> $past(state) != S_IDLE;
  endproperty
  a_int_first: assert property (p_int_first) else $error("deintegration skipped integrate");
  property p_shift_in;
    @(posedge clk_i) disable iff (!rst_b_i) sclk_rise |=>
      in_sr == {$past(in_sr[BYTE_W-2:0]), $past(din_s[2])};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("input bit not sampled");
endmodule : adc_ctrl

// *** rtl/adc_ctrl_pkg.sv ***
// Shared constants for the integrating converter control block
package adc_ctrl_pkg;
  localparam int BYTE_W = 8;
  localparam int RESULT_W = 20;
  localparam int CNT_W = 20;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  // Integration periods in oscillator clocks
  localparam logic [CNT_W-1:0] INT_CLKS_50HZ = 20'h0_028F;
  localparam logic [CNT_W-1:0] INT_CLKS_60HZ = 20'h0_0221;
  // Reset values
  localparam logic [3:0] USER_OUT_RST = 4'h0;
  localparam logic [7:0] CMD_RST = 8'h00;
  // Command byte fields: [7] start, [6] line mode (1 = 50 Hz), [5] user write, [3:0] user bits
  localparam int CMD_START_BIT = 7;
  localparam int CMD_MODE_BIT = 6;
  localparam int CMD_USER_BIT = 5;
  localparam int CMD_USER_LSB = 0;
  // Result bytes sent per read: three bytes, top first
  localparam int RESULT_BYTES = 3;
endpackage : adc_ctrl_pkg

// *** rtl/byte_fifo.sv ***
// Small valid/ready FIFO for result bytes
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [WIDTH-1:0] rd_data, next_rd_data;
  logic full, empty, push, pop;

  always_comb begin
    full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty = (wr_ptr == rd_ptr);
    push = in_valid_i && !full;
    pop = out_ready_i && !empty;
    next_wr_ptr = wr_ptr + {{AW{1'b0}}, push};
    next_rd_ptr = rd_ptr + {{AW{1'b0}}, pop};
    next_rd_data = mem[next_rd_ptr[AW-1:0]];
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rd_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      rd_data <= (push && next_rd_ptr == wr_ptr) ? in_data_i : next_rd_data;
    end
  end

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = rd_data;
endmodule : byte_fifo

// *** sim/serial_host.sv ***
// Host model driving the four-wire serial port of the converter
module serial_host (
  // Serial port pins
  output logic cs_b_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_line_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end

  task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    rx = '0;
    cs_b_o = 1'b0;
    #100;
    for (int i = nbits - 1; i >= 0; i--) begin
      din_o = tx[i];
      #24;
      sclk_o = 1'b1;
      #23;
      rx[i] = dout_line_i;
      #1;
      sclk_o = 1'b0;
    end
    #48;
    // Data in toggles at deselect with no serial clock edge, so it is never sampled
    din_o = ~din_o;
    cs_b_o = 1'b1;
    #100;
  endtask : frame
endmodule : serial_host

// *** sim/tb_top.sv ***
// Self-checking bench for the converter control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctrl_pkg::*;

  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic osc = 1'b0;
  logic zc = 1'b0;
  wire cs_b, sclk, din, dout, dout_oe, integ, deint, eoc, mode;
  wire [3:0] user;
  wire dout_line = dout_oe ? dout : 1'bz;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  serial_host host (
    .cs_b_o(cs_b),
    .sclk_o(sclk),
    .din_o(din),
    .dout_line_i(dout_line)
  );

  adc_ctrl uut (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cs_b_i(cs_b),
    .sclk_i(sclk),
    .din_i(din),
    .dout_o(dout),
    .dout_oe_o(dout_oe),
    .oscillator_in_i(osc),
    .zero_cross_i(zc),
    .integrate_o(integ),
    .deintegrate_o(deint),
    .eoc_o(eoc),
    .user_outputs_o(user),
    .mode_50hz_o(mode)
  );

  task automatic print_verdict;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] c);
    logic [23:0] rx;
    host.frame({16'h0000, c}, 8, rx);
    repeat (10) @(negedge clk_i);
  endtask : cmd

  task automatic osc_pulses(input int n);
    repeat (n) begin
      @(negedge clk_i) osc = 1'b1;
      repeat (4) @(negedge clk_i);
      osc = 1'b0;
      repeat (3) @(negedge clk_i);
    end
  endtask : osc_pulses

  task automatic convert(input logic m50, input int n_int, input logic [19:0] k);
    logic [23:0] rx;
    cmd({1'b1, m50, 6'h00});
    check(eoc, 1'b0, "eoc not cleared");
    check({integ, deint}, 2'b10, "integrate phase");
    check(mode, m50, "line mode");
    osc_pulses(n_int - 1);
    repeat (4) @(negedge clk_i);
    check({integ, deint}, 2'b10, "integrate ended early");
    osc_pulses(1);
    repeat (8) @(negedge clk_i);
    check({integ, deint}, 2'b01, "deintegrate phase");
    osc_pulses(k);
    zc = 1'b1;
    repeat (10) @(negedge clk_i);
    check({eoc, deint}, 2'b10, "end of conversion");
    zc = 1'b0;
    host.frame(24'h00_0000, 24, rx);
    check(rx, {4'h0, k}, "result bytes");
    host.frame(24'h00_0000, 8, rx);
    check(rx[7:0], 8'h00, "empty read");
    check(dout_oe, 1'b0, "dout released");
  endtask : convert

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("wrong value at %0t ns: run timed out", $time);
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check({eoc, user, mode, integ, deint, dout_oe}, 9'h000, "reset outputs");
    check(dout_oe, 1'b0, "idle dout");
    cmd(8'h2A);
    check(user, 4'hA, "user write");
    cmd(8'h05);
    check(user, 4'hA, "user held");
    cmd(8'h25);
    check(user, 4'h5, "user rewrite");
    $display("test user pins done");
    convert(1'b1, 655, 20'h0_0123);
    $display("test 50 Hz conversion done");
    convert(1'b0, 545, 20'h0_0005);
    $display("test 60 Hz conversion done");
    print_verdict();
  end
endmodule : tb_top
